// [ctc_top.sv]
/*
 * calibration and trim control: register bank behind the parallel
 * register pins, analog test switch controls, supply monitor routing and
 * trim source selection.
 * assumes the channel selection, monitor selection and programmed trim
 * bits come from logic on clk_in; the register pins are asynchronous.
 */
`timescale 1ns/1ps
`include "ctc_map.svh"

module ctc_top
(
    // clock, reset, enable
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic                    ce_in,
    // parallel register pins
    input  wire logic                    bus_cs_n_in,
    input  wire logic                    bus_rnw_in,
    input  wire logic [`CTC_ADDR_W-1:0]  bus_addr_in,
    input  wire logic [`CTC_DATA_W-1:0]  bus_data_in,
    output logic      [`CTC_DATA_W-1:0]  bus_data_out,
    output logic                         bus_data_oe_out,
    // device-side inputs
    input  wire logic [7:0]              mux_chan_sel_in,
    input  wire logic                    monitor_pos_supply_in,
    input  wire logic                    monitor_neg_supply_in,
    input  wire logic                    monitor_five_volt_in,
    input  wire logic                    monitor_reference_in,
    input  wire ctc_pkg::ctc_trim_t      prog_trim_in,
    // analog channel mux and test switches
    output logic [7:0]                   mux_chan_sel_out,
    output logic                         mux_sel_en_out,
    output logic                         amp_input_short_out,
    output logic                         inv_gnd_short_out,
    output logic                         isrc_to_pos_out,
    output logic                         isrc_to_inv_out,
    output logic                         pos_to_ref_div_out,
    // supply monitor routing
    output logic                         monitor_en_out,
    output ctc_pkg::ctc_rail_e           monitor_rail_out,
    output logic [2:0]                   monitor_div_out,
    // trims
    output ctc_pkg::ctc_trim_t           trim_out,
    output logic [3:0]                   amp_offset_trim_out,
    output logic [4:0]                   ref_trim_out
);
    import ctc_pkg::*;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // ----------------------------------------------------------------------
    // pin synchroniser and access detect
    // ----------------------------------------------------------------------
    logic [`CTC_SYNC_W-1:0] pins_s;
    logic                   cs_n_s;
    logic                   rnw_s;
    logic [4:0]             addr_s;
    logic [7:0]             wdata_s;
    logic                   cs_n_d_r;
    logic                   take;
    logic                   wr_take;
    logic                   rd_take;

    ctc_sync2 u_sync
    (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .async_in   ({bus_cs_n_in, bus_rnw_in, bus_addr_in, bus_data_in}),
        .sync_out   (pins_s)
    );

    assign {cs_n_s, rnw_s, addr_s, wdata_s} = pins_s;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cs_n_d_r <= 1'b1;
        else if (ce_in)
            cs_n_d_r <= cs_n_s;
    end

    // one access per strobe: address and data are stable by the time the
    // strobe edge has crossed both stages
    assign take    = cs_n_d_r & ~cs_n_s;
    assign wr_take = take & ~rnw_s;
    assign rd_take = take & rnw_s;

    function automatic logic trim_hit(input logic [4:0] a);
        trim_hit = (a >= `CTC_OFS_TRIM_FIRST) && (a <= `CTC_OFS_TRIM_LAST);
    endfunction

    function automatic logic [2:0] trim_idx(input logic [4:0] a);
        logic [4:0] d;
        d        = a - `CTC_OFS_TRIM_FIRST;
        trim_idx = d[2:0];
    endfunction

    // ----------------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------------
    ctc_byte_t cal_r;
    ctc_byte_t tsel_r;
    ctc_byte_t trim_r [0:`CTC_TRIM_NUM-1];
    ctc_trim_t user_trim;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cal_r  <= `CTC_CAL_RST;
            tsel_r <= `CTC_TSEL_RST;
        end
        else if (ce_in && wr_take)
        begin
            // unused bits are never stored, so they read back as zero
            if (addr_s == `CTC_OFS_CAL)
                cal_r <= wdata_s & `CTC_CAL_MASK;
            if (addr_s == `CTC_OFS_TSEL)
                tsel_r <= wdata_s & `CTC_TSEL_MASK;
        end
    end

    // while the copy bit is set the bytes track the programmed bits and
    // host writes to them are lost
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < `CTC_TRIM_NUM; i++)
                trim_r[i] <= `CTC_TRIM_RST;
        end
        else if (ce_in)
        begin
            if (tsel_r[`CTC_TSEL_IN_BIT])
            begin
                for (int i = 0; i < `CTC_TRIM_NUM; i++)
                    trim_r[i] <= prog_trim_in[i*8 +: 8];
            end
            else if (wr_take && trim_hit(addr_s))
                trim_r[trim_idx(addr_s)] <= wdata_s;
        end
    end

    always_comb
    begin
        for (int i = 0; i < `CTC_TRIM_NUM; i++)
            user_trim[i*8 +: 8] = trim_r[i];
    end

    // ----------------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------------
    ctc_byte_t rd_val;

    always_comb
    begin
        rd_val = `CTC_READ_NONE;
        if (addr_s == `CTC_OFS_CAL)
            rd_val = cal_r;
        else if (addr_s == `CTC_OFS_TSEL)
            rd_val = tsel_r;
        else if (trim_hit(addr_s))
            rd_val = trim_r[trim_idx(addr_s)];
    end

    // data is driven from the strobe edge until the strobe is seen released
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            bus_data_out    <= '0;
            bus_data_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (rd_take)
            begin
                bus_data_out    <= rd_val;
                bus_data_oe_out <= 1'b1;
            end
            else if (cs_n_s)
            begin
                bus_data_out    <= '0;
                bus_data_oe_out <= 1'b0;
            end
        end
    end

    chk_read_back: assert property (rd_take && ce_in && addr_s == `CTC_OFS_CAL
        |=> bus_data_oe_out && bus_data_out == $past(cal_r))
        else $error("calibration read returned wrong value");
    chk_unused_zero: assert property (((cal_r & ~`CTC_CAL_MASK) == 8'h00)
        && ((tsel_r & ~`CTC_TSEL_MASK) == 8'h00))
        else $error("unused control bit is set");

    // ----------------------------------------------------------------------
    // analog test switches
    // ----------------------------------------------------------------------
    logic override;
    logic pos_cc;
    logic inv_cc;

    assign override = cal_r[`CTC_CAL_SHORT_BIT] | cal_r[`CTC_CAL_IGND_BIT];
    assign pos_cc   = cal_r[`CTC_CAL_POS_CC_BIT];
    // both checks at once would fight over the source; the
    // non-inverting check wins and the inverting one stays open
    assign inv_cc   = cal_r[`CTC_CAL_INV_CC_BIT] & ~pos_cc;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            mux_chan_sel_out    <= '0;
            mux_sel_en_out      <= 1'b0;
            amp_input_short_out <= 1'b0;
            inv_gnd_short_out   <= 1'b0;
            isrc_to_pos_out     <= 1'b0;
            isrc_to_inv_out     <= 1'b0;
            pos_to_ref_div_out  <= 1'b0;
        end
        else if (ce_in)
        begin
            mux_chan_sel_out    <= override ? 8'h00 : mux_chan_sel_in;
            mux_sel_en_out      <= ~override;
            amp_input_short_out <= cal_r[`CTC_CAL_SHORT_BIT];
            inv_gnd_short_out   <= cal_r[`CTC_CAL_IGND_BIT];
            isrc_to_pos_out     <= pos_cc;
            isrc_to_inv_out     <= inv_cc;
            pos_to_ref_div_out  <= inv_cc;
        end
    end

    chk_short_override: assert property (ce_in && cal_r[`CTC_CAL_SHORT_BIT]
        |=> amp_input_short_out && !mux_sel_en_out)
        else $error("input short did not override channel selection");
    chk_gnd_override: assert property (ce_in && cal_r[`CTC_CAL_IGND_BIT]
        |=> inv_gnd_short_out && mux_chan_sel_out == 8'h00)
        else $error("ground short did not override channel selection");
    chk_pos_source: assert property (ce_in && cal_r[`CTC_CAL_POS_CC_BIT]
        |=> isrc_to_pos_out && !isrc_to_inv_out)
        else $error("current source not on non-inverting input");
    chk_inv_source: assert property (ce_in && cal_r[`CTC_CAL_INV_CC_BIT]
        && !cal_r[`CTC_CAL_POS_CC_BIT]
        |=> isrc_to_inv_out && pos_to_ref_div_out && !isrc_to_pos_out)
        else $error("inverting continuity routing wrong");

    // ----------------------------------------------------------------------
    // supply monitor routing
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            monitor_en_out   <= 1'b0;
            monitor_rail_out <= CTC_RAIL_POS;
            monitor_div_out  <= `CTC_MON_DIV_HV;
        end
        else if (ce_in)
        begin
            monitor_en_out <= monitor_pos_supply_in | monitor_neg_supply_in
                            | monitor_five_volt_in | monitor_reference_in;
            // fixed priority if several selections are raised at once
            if (monitor_pos_supply_in)
            begin
                monitor_rail_out <= CTC_RAIL_POS;
                monitor_div_out  <= `CTC_MON_DIV_HV;
            end
            else if (monitor_neg_supply_in)
            begin
                monitor_rail_out <= CTC_RAIL_NEG;
                monitor_div_out  <= `CTC_MON_DIV_HV;
            end
            else if (monitor_five_volt_in)
            begin
                monitor_rail_out <= CTC_RAIL_FIVE;
                monitor_div_out  <= `CTC_MON_DIV_LV;
            end
            else if (monitor_reference_in)
            begin
                monitor_rail_out <= CTC_RAIL_REF;
                monitor_div_out  <= `CTC_MON_DIV_LV;
            end
        end
    end

    chk_monitor_hv: assert property (ce_in && (monitor_pos_supply_in || monitor_neg_supply_in)
        |=> monitor_en_out && monitor_div_out == 3'h6)
        else $error("high voltage rail divider wrong");
    chk_monitor_ref: assert property (ce_in && monitor_reference_in && !monitor_pos_supply_in
        && !monitor_neg_supply_in && !monitor_five_volt_in
        |=> monitor_rail_out == CTC_RAIL_REF && monitor_div_out == 3'h2)
        else $error("reference rail routing wrong");

    // ----------------------------------------------------------------------
    // trim outputs
    // ----------------------------------------------------------------------
    ctc_trim_mux u_trim
    (
        .clk_in              (clk_in),
        .sys_rst_in          (sys_rst_in),
        .ce_in               (ce_in),
        .use_user_in         (tsel_r[`CTC_TSEL_OUT_BIT]),
        .user_trim_in        (user_trim),
        .prog_trim_in        (prog_trim_in),
        .trim_out            (trim_out),
        .amp_offset_trim_out (amp_offset_trim_out),
        .ref_trim_out        (ref_trim_out)
    );

    chk_trim_user: assert property (ce_in && tsel_r[`CTC_TSEL_OUT_BIT]
        |=> trim_out == $past(user_trim))
        else $error("trims not taken from user registers");
    chk_trim_prog: assert property (ce_in && !tsel_r[`CTC_TSEL_OUT_BIT]
        |=> trim_out == $past(prog_trim_in))
        else $error("trims not taken from programmed bits");
    chk_default_copy: assert property (ce_in && tsel_r[`CTC_TSEL_IN_BIT]
        |=> user_trim == $past(prog_trim_in))
        else $error("programmed trims not copied");
    chk_offset_field: assert property (amp_offset_trim_out == trim_out[11:8])
        else $error("offset trim field mismatch");
    chk_ref_field: assert property (ref_trim_out == trim_out[4:0])
        else $error("reference trim field mismatch");

    cov_short_write: cover property (wr_take && ce_in && addr_s == `CTC_OFS_CAL
        && wdata_s[`CTC_CAL_SHORT_BIT] ##1 cal_r[`CTC_CAL_SHORT_BIT]);
    cov_inv_check: cover property (isrc_to_inv_out && pos_to_ref_div_out);
    cov_copy_then_user: cover property (tsel_r[`CTC_TSEL_IN_BIT]
        ##1 tsel_r == 8'h02);
    cov_trim_read: cover property (rd_take && trim_hit(addr_s) ##1 bus_data_oe_out);

endmodule

// [ctc_map.svh]
/*
 * register offsets, field positions, reset values and sync figures of the
 * calibration and trim control block.
 * assumes it is included by bare name in every file that needs a figure.
 */
// What this block does
// - calibration bit 7 shorts both amplifier inputs
// - calibration bit 1 grounds inverting amplifier input
// - calibration bit 4 routes current to non-inverting
// - bit 3 with bit 4 clear: current inverting, non-inverting to reference
// - select bit 1 chooses user or programmed trims
// - select bit 0 copies programmed trims to registers
// - offset trim from register 19 bits 3-0
// - reference trim from register 18 bits 4-0
// - supply monitor divides by 6 or 2
`ifndef CTC_MAP_SVH
`define CTC_MAP_SVH

// ----------------------------------------------------------------------
// register bus
// ----------------------------------------------------------------------
`define CTC_ADDR_W          5
`define CTC_DATA_W          8
`define CTC_OFS_CAL         5'h10
`define CTC_OFS_TSEL        5'h11
`define CTC_OFS_TRIM_FIRST  5'h12
`define CTC_OFS_TRIM_LAST   5'h16
`define CTC_TRIM_NUM        5
`define CTC_TRIM_W          40
`define CTC_READ_NONE       8'h00

// ----------------------------------------------------------------------
// calibration test control fields
// ----------------------------------------------------------------------
`define CTC_CAL_SHORT_BIT   7
`define CTC_CAL_POS_CC_BIT  4
`define CTC_CAL_INV_CC_BIT  3
`define CTC_CAL_IGND_BIT    1
`define CTC_CAL_MASK        8'h9A
`define CTC_CAL_RST         8'h00

// ----------------------------------------------------------------------
// trim source select fields
// ----------------------------------------------------------------------
`define CTC_TSEL_OUT_BIT    1
`define CTC_TSEL_IN_BIT     0
`define CTC_TSEL_MASK       8'h03
`define CTC_TSEL_RST        8'h00
`define CTC_TRIM_RST        8'h00

// offset trim sits in the second trim byte, reference trim in the first
`define CTC_OFS_TRIM_LSB    8
`define CTC_OFS_TRIM_MSB    11
`define CTC_REF_TRIM_LSB    0
`define CTC_REF_TRIM_MSB    4

// ----------------------------------------------------------------------
// supply monitor dividers and pin synchroniser
// ----------------------------------------------------------------------
`define CTC_MON_DIV_HV      3'h6
`define CTC_MON_DIV_LV      3'h2
`define CTC_SYNC_W          15
`define CTC_SYNC_RST        15'h4000

`endif

// [ctc_pkg.sv]
/*
 * types shared by the calibration and trim control files.
 * assumes nothing of its surroundings.
 */
package ctc_pkg;

    typedef logic [7:0]  ctc_byte_t;
    typedef logic [39:0] ctc_trim_t;

    // rail routed to the converter path while monitoring
    typedef enum logic [1:0]
    {
        CTC_RAIL_POS  = 2'b00,
        CTC_RAIL_NEG  = 2'b01,
        CTC_RAIL_FIVE = 2'b10,
        CTC_RAIL_REF  = 2'b11
    } ctc_rail_e;

endpackage

// [ctc_sync2.sv]
/*
 * two-stage synchroniser for the parallel register pins.
 * assumes the pins are held stable while the strobe is active.
 */
`timescale 1ns/1ps
`include "ctc_map.svh"

module ctc_sync2
(
    // clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    input  wire logic                   ce_in,
    // pins and their synchronised copy
    input  wire logic [`CTC_SYNC_W-1:0] async_in,
    output logic      [`CTC_SYNC_W-1:0] sync_out
);
    import ctc_pkg::*;

    logic [`CTC_SYNC_W-1:0] meta_r;

    // the first stage is read by the second stage only
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            meta_r   <= `CTC_SYNC_RST;
            sync_out <= `CTC_SYNC_RST;
        end
        else if (ce_in)
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// [ctc_trim_mux.sv]
/*
 * registered trim output selector.
 * assumes the user trim bytes and programmed bits are on clk_in.
 */
`timescale 1ns/1ps
`include "ctc_map.svh"

module ctc_trim_mux
(
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic                  ce_in,
    // trim sources
    input  wire logic                  use_user_in,
    input  wire ctc_pkg::ctc_trim_t    user_trim_in,
    input  wire ctc_pkg::ctc_trim_t    prog_trim_in,
    // selected trims
    output ctc_pkg::ctc_trim_t         trim_out,
    output logic [3:0]                 amp_offset_trim_out,
    output logic [4:0]                 ref_trim_out
);
    import ctc_pkg::*;

    ctc_trim_t sel_trim;

    assign sel_trim = use_user_in ? user_trim_in : prog_trim_in;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            trim_out            <= '0;
            amp_offset_trim_out <= '0;
            ref_trim_out        <= '0;
        end
        else if (ce_in)
        begin
            trim_out            <= sel_trim;
            amp_offset_trim_out <= sel_trim[`CTC_OFS_TRIM_MSB:`CTC_OFS_TRIM_LSB];
            ref_trim_out        <= sel_trim[`CTC_REF_TRIM_MSB:`CTC_REF_TRIM_LSB];
        end
    end

endmodule

// [ctc_host.sv]
/*
 * host model on the parallel register pins: byte writes and reads.
 * assumes clk_in runs free and callers start after reset release.
 */
`timescale 1ns/1ps

module ctc_host
(
    // clock
    input  wire logic       clk_in,
    // register pins
    output logic            bus_cs_n_out,
    output logic            bus_rnw_out,
    output logic [4:0]      bus_addr_out,
    output logic [7:0]      bus_data_out,
    input  wire logic [7:0] bus_data_in,
    input  wire logic       bus_data_oe_in
);
    initial
    begin
        bus_cs_n_out = 1'b1;
        bus_rnw_out  = 1'b1;
        bus_addr_out = 5'h00;
        bus_data_out = 8'h00;
    end

    // ------------------------------------------------------------------
    // strobe timing
    // ------------------------------------------------------------------
    // released lines flip so nothing can pass on a stale copy
    task automatic release_bus();
        bus_cs_n_out <= 1'b1;
        bus_addr_out <= ~bus_addr_out;
        bus_data_out <= ~bus_data_out;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_cs_n_out <= 1'b0;
        bus_rnw_out  <= 1'b0;
        bus_addr_out <= a;
        bus_data_out <= d;
        repeat (4) @(posedge clk_in);
        release_bus();
    endtask

    // strobe stays low at least three clocks even if data comes early
    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk_in);
        bus_cs_n_out <= 1'b0;
        bus_rnw_out  <= 1'b1;
        bus_addr_out <= a;
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk_in);
            if (bus_data_oe_in === 1'b1)
            begin
                ok = 1'b1;
                d = bus_data_in;
            end
        end
        if (n < 3)
            repeat (3 - n) @(posedge clk_in);
        release_bus();
    endtask
endmodule

// [calibration_trim_control_test.sv]
/*
 * self-checking bench: host model plus integer register model.
 * assumes ctc_map.svh and ctc_pkg are compiled ahead of this file.
 */
`timescale 1ns/1ps
`include "ctc_map.svh"

module calibration_trim_control_test;
    import ctc_pkg::*;
    logic       clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic       cs_n, rnw, oe, mux_en, short, ignd, ipos, iinv, refdiv, mon_en;
    logic [4:0] addr, reft;
    logic [7:0] wdata, rdata, mux_chan;
    logic [7:0] chan_sel = 8'h00;
    logic       ce = 1'b1;
    logic [3:0] mon_sel = 4'h0;
    logic [3:0] offs;
    logic [2:0] mon_div;
    ctc_rail_e  mon_rail;
    ctc_trim_t  trim;
    ctc_trim_t  prog_trim = '0;
    int         cal_m, tsel_m, fails, compares, a, i;
    int         trim_m[5];

    ctc_host i_ctc_host (.clk_in(clk_in), .bus_cs_n_out(cs_n), .bus_rnw_out(rnw),
        .bus_addr_out(addr), .bus_data_out(wdata), .bus_data_in(rdata),
        .bus_data_oe_in(oe));
    ctc_top i_ctc_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
        .bus_cs_n_in(cs_n), .bus_rnw_in(rnw), .bus_addr_in(addr), .bus_data_in(wdata),
        .bus_data_out(rdata), .bus_data_oe_out(oe), .mux_chan_sel_in(chan_sel),
        .monitor_pos_supply_in(mon_sel[0]), .monitor_neg_supply_in(mon_sel[1]),
        .monitor_five_volt_in(mon_sel[2]), .monitor_reference_in(mon_sel[3]),
        .prog_trim_in(prog_trim), .mux_chan_sel_out(mux_chan), .mux_sel_en_out(mux_en),
        .amp_input_short_out(short), .inv_gnd_short_out(ignd), .isrc_to_pos_out(ipos),
        .isrc_to_inv_out(iinv), .pos_to_ref_div_out(refdiv), .monitor_en_out(mon_en),
        .monitor_rail_out(mon_rail), .monitor_div_out(mon_div), .trim_out(trim),
        .amp_offset_trim_out(offs), .ref_trim_out(reft));

    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end

    // ------------------------------------------------------------------
    // checking and model
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // copy bit is a level: trim bytes track the programmed bits
    task automatic wr(input int ad, input int d);
        i_ctc_host.wr(ad[4:0], d[7:0]);
        if (ad == 16)
            cal_m = d & 'h9A;
        if (ad == 17)
            tsel_m = d & 'h03;
        if (ad >= 18 && ad <= 22)
            trim_m[ad-18] = d & 'hFF;
        if (tsel_m[0])
            for (int k = 0; k < 5; k++)
                trim_m[k] = prog_trim[8*k+:8];
    endtask

    function automatic int exp_reg(input int ad);
        if (ad == 16)
            return cal_m;
        if (ad == 17)
            return tsel_m;
        if (ad >= 18 && ad <= 22)
            return trim_m[ad-18];
        return 0;
    endfunction

    task automatic rd_chk(input int ad);
        logic [7:0] d;
        logic       ok;
        i_ctc_host.rd(ad[4:0], d, ok);
        if (ok !== 1'b1)
        begin
            fails++;
            $display("ERROR read strobe expected 1 seen %b", ok);
            close_out();
        end
        else
        begin
            chk("read data", 40'(exp_reg(ad)), {32'h0, d});
            // the drive is dropped at the edge that ends the release wait
            @(posedge clk_in);
            chk("read drive release", 40'h0, {39'h0, oe});
        end
    endtask

    task automatic chk_outs();
        logic [39:0] sel;
        for (int k = 0; k < 5; k++)
            sel[8*k+:8] = trim_m[k][7:0];
        if (!tsel_m[1])
            sel = prog_trim;
        chk("channel select", (cal_m & 'h82) ? 40'h0 : chan_sel, mux_chan);
        chk("select enable", (cal_m & 'h82) == 0, mux_en);
        chk("input short", cal_m[7], short);
        chk("inverting ground", cal_m[1], ignd);
        chk("source to pos", cal_m[4], ipos);
        chk("source to inv", cal_m[3] & !cal_m[4], iinv);
        chk("pos to ref div", cal_m[3] & !cal_m[4], refdiv);
        chk("trim out", sel, trim);
        chk("offset trim", sel[11:8], offs);
        chk("reference trim", sel[4:0], reft);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h7240ac2b));
        prog_trim <= {8'($urandom), 32'($urandom)};
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk_outs();
        for (a = 16; a <= 22; a++)
            rd_chk(a);
        chan_sel <= 8'h55;
        for (i = 0; i < 8; i++)
        begin
            wr(16, 1 << i);
            rd_chk(16);
            chk_outs();
        end
        for (i = 0; i < 6; i++)
        begin
            chan_sel <= 8'($urandom);
            wr(16, $urandom);
            rd_chk(16);
            chk_outs();
        end
        wr(16, 'h18);
        chk_outs();
        wr(16, 0);
        for (a = 18; a <= 22; a++)
            wr(a, $urandom);
        wr(17, 'hFE);
        rd_chk(17);
        chk_outs();
        wr(17, 'h01);
        for (a = 18; a <= 22; a++)
            rd_chk(a);
        wr(18, 'hA5);
        rd_chk(18);
        wr(17, 'h02);
        chk_outs();
        wr(17, 'h00);
        prog_trim <= {8'($urandom), 32'($urandom)};
        repeat (3) @(posedge clk_in);
        chk_outs();
        wr(5, 'hFF);
        rd_chk(5);
        rd_chk(31);
        for (i = 0; i < 5; i++)
        begin
            mon_sel <= (i < 4) ? 4'(1 << i) : 4'hF;
            repeat (3) @(posedge clk_in);
            chk("monitor enable", 40'h1, {39'h0, mon_en});
            chk("monitor rail", (i < 4) ? i : 0, mon_rail);
            chk("monitor divider", (i < 2 || i == 4) ? 6 : 2, mon_div);
        end
        mon_sel <= 4'h0;
        repeat (3) @(posedge clk_in);
        chk("monitor idle", 40'h0, {39'h0, mon_en});
        // enable low must freeze the routed channel selection
        ce <= 1'b0;
        a = mux_chan;
        chan_sel <= ~mux_chan;
        repeat (3) @(posedge clk_in);
        chk("frozen select", 40'(a), mux_chan);
        ce <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk_outs();
        close_out();
    end
endmodule
